//--- rtl/adc_break_ctrl.sv
// converter start, sequencing and result validity around emulator breaks
// assumes synchronous inputs, one clock, strobe register port, break level from debug logic
//
// Summary of operation
// - while stop-on-break is on, the conversion engine freezes for the whole break.
// - with stop-on-break on, a break within two executed instructions after a start trigger cancels that start.
// - a start cancelled by a break never raises the completion interrupt.
// - a software start whose instruction carries a pre-execution break does not start.
// - with stop-on-break on, start attempts made during a break that began with the converter idle are ignored.
// - trigger cancellation covers memory transfer, external, timer and instruction starts.
// - a config write in a break that froze a conversion gives one or two old-setting runs first.
// - in normal conversion mode the stale runs number two, otherwise one.
// - every stale run still yields a result and a completion interrupt.
// - with no break, a config write takes effect at once on the next conversion.
// - the first result after resuming from a frozen conversion is flagged invalid.
// - in high-speed mode, enable cleared and set in such a break flags the next result invalid.
// - the tracked config set is the three mode, channel, and two power-fail registers.
// - config writes count whether from the register view or from a memory transfer.
// - every break source feeds the break input; real-time monitoring raises no break.
//
// Chosen here: the register offsets and strobed register access.
module adc_break_ctrl
  import adc_brk_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        dma_cfg_wr,
  input  wire logic        stop_on_break,
  input  wire logic        break_active,
  input  wire logic        insn_retired,
  input  wire logic        sw_start_prebreak,
  input  wire logic        trig_dma,
  input  wire logic        trig_ext,
  input  wire logic        trig_timer,
  input  wire logic [9:0]  sample_in,
  output logic      [7:0]  reg_rdata,
  output logic             conv_done_irq,
  output logic             irq,
  output logic             busy
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    cfg_s       cfg;
    cfg_s       act;
    conv_e      st;
    logic [7:0] cnt;
    logic       pend;
    logic [1:0] insns;
    logic [1:0] stale;
    logic       pend_cfg;
    logic       inval_next;
    logic       en_cleared;
    logic       idle_brk;
    logic [9:0] result;
    logic       res_bad;
    logic [2:0] ist;
    logic [2:0] imask;
    logic [7:0] rdata;
    logic       done;
    logic       irq;
    logic       busy;
  } state_s;

  state_s     s_q;
  state_s     s_d;
  reg_req_s   req;
  logic       frz;
  logic       trig;
  logic       cfg_hit;
  logic [2:0] ev;

  assign req     = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
  assign frz     = stop_on_break & break_active;
  assign trig    = trig_dma | trig_ext | trig_timer;
  assign cfg_hit = (req.wr | dma_cfg_wr) & (req.addr <= ADDR_PF_MODE);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    ev       = 3'h0;

    // config writes land in the software copy; engine copy may lag
    if (cfg_hit) begin
      case (req.addr)
        ADDR_MODE0: s_d.cfg.mode0 = req.wdata;
        ADDR_MODE1: s_d.cfg.mode1 = req.wdata;
        ADDR_MODE2: s_d.cfg.mode2 = req.wdata;
        ADDR_CHSEL: s_d.cfg.chsel = req.wdata;
        ADDR_PF_THR: s_d.cfg.pf_thr = req.wdata;
        default: s_d.cfg.pf_mode = req.wdata;
      endcase
      if (frz && s_q.st == ST_FROZEN && !s_q.pend_cfg) begin
        s_d.pend_cfg = 1'b1;
        s_d.stale    = s_q.act.mode0[MODE0_NORMAL] ? 2'h2 : 2'h1;
      end
      if (frz && req.addr == ADDR_MODE0 && s_q.st == ST_FROZEN) begin
        if (!req.wdata[MODE0_ENABLE])
          s_d.en_cleared = 1'b1;
        else if (s_q.en_cleared && s_q.act.mode0[MODE0_HISPEED])
          s_d.inval_next = 1'b1;
      end
    end

    if (frz && s_q.st == ST_IDLE)
      s_d.idle_brk = 1'b1;
    else if (!frz)
      s_d.idle_brk = 1'b0;

    case (s_q.st)
      ST_IDLE: begin
        if (s_q.pend) begin
          if (frz) begin
            s_d.pend = 1'b0;
            ev[IRQ_DROP] = 1'b1;
          end else if (s_q.insns == GUARD_INSNS) begin
            s_d.pend = 1'b0;
            s_d.st   = ST_CONV;
            s_d.cnt  = CONV_CYCLES_W;
            if (!s_q.pend_cfg)
              s_d.act = s_d.cfg;
          end else if (insn_retired) begin
            s_d.insns = s_q.insns + 2'h1;
          end
        end else if (!frz && !s_q.idle_brk && s_q.cfg.mode0[MODE0_ENABLE]) begin
          if (trig || (req.wr && req.addr == ADDR_MODE0 && req.wdata[MODE0_SW_START])) begin
            if (sw_start_prebreak && !trig) begin
              ev[IRQ_DROP] = 1'b1;
            end else begin
              s_d.pend  = 1'b1;
              s_d.insns = 2'h0;
            end
          end
        end else if (frz && trig) begin
          ev[IRQ_DROP] = 1'b1;
        end
        if (!frz && s_q.pend_cfg && !s_q.pend && s_q.stale != 2'h0) begin
          s_d.st  = ST_CONV;
          s_d.cnt = CONV_CYCLES_W;
        end
      end
      ST_CONV: begin
        if (frz) begin
          s_d.st = ST_FROZEN;
        end else if (s_q.cnt == 8'h01) begin
          s_d.result  = sample_in;
          s_d.res_bad = s_q.inval_next;
          s_d.inval_next = 1'b0;
          s_d.done    = 1'b1;
          ev[IRQ_DONE] = 1'b1;
          if (s_q.inval_next)
            ev[IRQ_INVALID] = 1'b1;
          s_d.st = ST_IDLE;
          if (s_q.pend_cfg) begin
            s_d.stale = s_q.stale - 2'h1;
            if (s_q.stale == 2'h1) begin
              s_d.pend_cfg = 1'b0;
              s_d.act      = s_q.cfg;
            end
          end
        end else begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
      ST_FROZEN: begin
        if (!frz) begin
          s_d.st         = ST_CONV;
          s_d.inval_next = 1'b1;
          s_d.en_cleared = 1'b0;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase

    // sticky status: set wins over write-one-to-clear
    if (req.wr && req.addr == ADDR_IRQ_STAT)
      s_d.ist = s_q.ist & ~req.wdata[2:0];
    s_d.ist = s_d.ist | ev;
    if (req.wr && req.addr == ADDR_IRQ_MASK)
      s_d.imask = req.wdata[2:0];
    s_d.irq  = |(s_d.ist & s_d.imask);
    s_d.busy = (s_d.st != ST_IDLE) | s_d.pend;

    s_d.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        ADDR_MODE0:    s_d.rdata = s_q.cfg.mode0;
        ADDR_MODE1:    s_d.rdata = s_q.cfg.mode1;
        ADDR_MODE2:    s_d.rdata = s_q.cfg.mode2;
        ADDR_CHSEL:    s_d.rdata = s_q.cfg.chsel;
        ADDR_PF_THR:   s_d.rdata = s_q.cfg.pf_thr;
        ADDR_PF_MODE:  s_d.rdata = s_q.cfg.pf_mode;
        ADDR_STATUS:   s_d.rdata = {2'h0, s_q.res_bad, s_q.pend_cfg, s_q.stale, s_q.st};
        ADDR_IRQ_STAT: s_d.rdata = {5'h00, s_q.ist};
        ADDR_IRQ_MASK: s_d.rdata = {5'h00, s_q.imask};
        ADDR_RESULT:   s_d.rdata = s_q.result[9:2];
        default:       s_d.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q       <= '0;
      s_q.cfg   <= {6{RESET_CFG}};
      s_q.act   <= {6{RESET_CFG}};
      s_q.st    <= ST_IDLE;
      s_q.ist   <= IRQ_RESET;
      s_q.imask <= IRQ_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata     = s_q.rdata;
  assign conv_done_irq = s_q.done;
  assign irq           = s_q.irq;
  assign busy          = s_q.busy;

endmodule

//--- shared/adc_brk_pkg.sv
// package for the converter break-interaction controller
// assumes a single 200 MHz clock and a plain strobe register port
package adc_brk_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_PERIOD_NS   = 5;
  localparam int          CONV_TIME_NS    = 200;
  localparam int          CONV_CYCLES     = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  CONV_CYCLES_W   = 8'(CONV_CYCLES);
  localparam logic [1:0]  GUARD_INSNS     = 2'h2;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [3:0]  ADDR_MODE0      = 4'h0;
  localparam logic [3:0]  ADDR_MODE1      = 4'h1;
  localparam logic [3:0]  ADDR_MODE2      = 4'h2;
  localparam logic [3:0]  ADDR_CHSEL      = 4'h3;
  localparam logic [3:0]  ADDR_PF_THR     = 4'h4;
  localparam logic [3:0]  ADDR_PF_MODE    = 4'h5;
  localparam logic [3:0]  ADDR_STATUS     = 4'h6;
  localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h7;
  localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h8;
  localparam logic [3:0]  ADDR_RESULT     = 4'h9;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int          MODE0_ENABLE    = 7;
  localparam int          MODE0_SW_START  = 6;
  localparam int          MODE0_HISPEED   = 0;
  localparam int          MODE0_NORMAL    = 1;
  localparam logic [7:0]  RESET_CFG       = 8'h00;
  localparam int          IRQ_DONE        = 0;
  localparam int          IRQ_DROP        = 1;
  localparam int          IRQ_INVALID     = 2;
  localparam logic [2:0]  IRQ_RESET       = 3'h0;

  typedef struct packed {
    logic [7:0] mode0;
    logic [7:0] mode1;
    logic [7:0] mode2;
    logic [7:0] chsel;
    logic [7:0] pf_thr;
    logic [7:0] pf_mode;
  } cfg_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_FROZEN
  } conv_e;

endpackage

//--- tb/adc_break_asserts.sv
// checker for the converter break controller
// assumes bind onto adc_break_ctrl, one clock, async low reset
module adc_break_asserts
  import adc_brk_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       stop_on_break,
  input wire logic       break_active,
  input wire logic       sw_start_prebreak,
  input wire logic [7:0] reg_rdata,
  input wire logic       conv_done_irq,
  input wire logic       irq,
  input wire logic       busy
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic mask_done_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      mask_done_q <= 1'b0;
    else if (reg_wr && reg_addr == ADDR_IRQ_MASK)
      mask_done_q <= reg_wdata[IRQ_DONE];
  end
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside slot");
  done_pulse_a: assert property (conv_done_irq |=> !conv_done_irq [*8])
    else $error("done pulse too long");
  done_cause_a: assert property (conv_done_irq |-> $past(busy)) else $error("done without conversion");
  brk_freeze_a: assert property (stop_on_break && break_active && $past(break_active) |-> !conv_done_irq)
    else $error("done during break");
  idle_brk_a: assert property (stop_on_break && break_active && !busy |=> !busy)
    else $error("start during idle break");
  pre_brk_a: assert property (reg_wr && reg_addr == ADDR_MODE0 && reg_wdata[MODE0_SW_START] &&
    sw_start_prebreak && !busy |=> !busy) else $error("start with break mark");
  start_done_a: assert property ($rose(busy) && !stop_on_break |-> ##[2:200] conv_done_irq)
    else $error("conversion never done");
  irq_done_a: assert property (conv_done_irq && mask_done_q && !reg_wr |-> ##[0:2] irq)
    else $error("done irq missing");
endmodule

bind adc_break_ctrl adc_break_asserts u_asserts (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .stop_on_break(stop_on_break),
  .break_active(break_active), .sw_start_prebreak(sw_start_prebreak), .reg_rdata(reg_rdata),
  .conv_done_irq(conv_done_irq), .irq(irq), .busy(busy));

//--- tb/brk_partner.sv
// cpu and break controller model: halt level and retire pulses
// assumes the bench requests breaks on brk_req
module brk_partner (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic brk_req,
  output logic      break_active,
  output logic      insn_retired
);
  timeunit 1ns;
  timeprecision 100ps;
  logic phase_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      break_active <= 1'b0;
      insn_retired <= 1'b0;
      phase_q <= 1'b0;
    end else begin
      break_active <= brk_req;
      phase_q <= ~phase_q;
      // halted cpu retires nothing
      insn_retired <= phase_q & ~brk_req & ~break_active;
    end
  end
endmodule

//--- tb/test_adc_break_ctrl.sv
// self-checking bench for the converter break controller
// assumes brk_partner and the bound checker
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_adc_break_ctrl
  import adc_brk_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, dma_cfg_wr = 1'b0, brk_req = 1'b0;
  logic       stop_on_break = 1'b0, sw_start_prebreak = 1'b0, trig_dma = 1'b0, trig_ext = 1'b0, trig_timer = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
  logic [9:0] sample_in = 10'h2a5;
  logic       conv_done_irq, irq, busy, break_active, insn_retired;
  int         n_errors = 0, num_checks = 0, c;
  always #2.5 sys_clk = ~sys_clk;
  brk_partner u_cpu (.sys_clk(sys_clk), .rst_n(rst_n), .brk_req(brk_req), .break_active(break_active),
    .insn_retired(insn_retired));
  adc_break_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .dma_cfg_wr(dma_cfg_wr), .stop_on_break(stop_on_break), .break_active(break_active),
    .insn_retired(insn_retired), .sw_start_prebreak(sw_start_prebreak), .trig_dma(trig_dma), .trig_ext(trig_ext),
    .trig_timer(trig_timer), .sample_in(sample_in), .reg_rdata(reg_rdata), .conv_done_irq(conv_done_irq),
    .irq(irq), .busy(busy));
  // ****************************************
  // bus and stimulus tasks
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic dma);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= ~dma;
    dma_cfg_wr <= dma;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    dma_cfg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic fire(input int w, input logic b);
    @(posedge sys_clk);
    trig_dma <= w == 0;
    trig_ext <= w == 1;
    trig_timer <= w == 2;
    brk_req <= b;
    @(posedge sys_clk);
    {trig_dma, trig_ext, trig_timer} <= 3'h0;
  endtask
  task automatic brk(input logic b);
    @(posedge sys_clk);
    brk_req <= b;
  endtask
  task automatic count(input int n);
    c = 0;
    repeat (n) begin
      @(posedge sys_clk);
      #1 if (conv_done_irq === 1'b1) c++;
    end
  endtask
  task automatic wait_idle;
    int k;
    for (k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge sys_clk);
    if (busy !== 1'b0) begin
      n_errors++;
      test_done;
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_normal;
    wr(ADDR_IRQ_MASK, 8'h07, 1'b0);
    wr(ADDR_MODE0, 8'h80, 1'b0);
    fire(2, 1'b0);
    #1 `CHK(busy, 1'b1)
    count(120);
    `CHK(c, 1)
    `CHK(irq, 1'b1)
    rd(ADDR_RESULT);
    `CHK(d, 8'ha9)
    wr(ADDR_IRQ_STAT, 8'h07, 1'b0);
    wr(ADDR_IRQ_MASK, 8'h00, 1'b0);
    fire(0, 1'b0);
    count(120);
    `CHK(irq, 1'b0)
    rd(ADDR_IRQ_STAT);
    `CHK(d[IRQ_DONE], 1'b1)
    wr(ADDR_IRQ_STAT, 8'h07, 1'b0);
    rd(4'hf);
    `CHK(d, 8'h00)
    $display("t_normal end");
  endtask
  task automatic t_drop;
    int w;
    stop_on_break <= 1'b1;
    for (w = 0; w < 3; w++) begin
      fire(w, 1'b1);
      repeat (10) @(posedge sys_clk);
      brk(1'b0);
      count(120);
      `CHK(c, 0)
      rd(ADDR_IRQ_STAT);
      `CHK(d[IRQ_DROP], 1'b1)
      wr(ADDR_IRQ_STAT, 8'h07, 1'b0);
      wait_idle;
    end
    $display("t_drop end");
  endtask
  task automatic t_idle;
    @(posedge sys_clk);
    sw_start_prebreak <= 1'b1;
    wr(ADDR_MODE0, 8'hc0, 1'b0);
    sw_start_prebreak <= 1'b0;
    count(120);
    `CHK(c, 0)
    brk(1'b1);
    repeat (4) @(posedge sys_clk);
    fire(1, 1'b1);
    wr(ADDR_MODE0, 8'hc0, 1'b0);
    brk(1'b0);
    count(120);
    `CHK(c, 0)
    $display("t_idle end");
  endtask
  task automatic t_stale;
    wr(ADDR_MODE0, 8'h82, 1'b0);
    wr(ADDR_IRQ_STAT, 8'h07, 1'b0);
    fire(2, 1'b0);
    repeat (20) @(posedge sys_clk);
    brk(1'b1);
    repeat (5) @(posedge sys_clk);
    wr(ADDR_CHSEL, 8'h01, 1'b0);
    wr(ADDR_MODE1, 8'h10, 1'b1);
    brk(1'b0);
    count(400);
    `CHK(c >= 2, 1'b1)
    rd(ADDR_IRQ_STAT);
    `CHK(d[IRQ_INVALID], 1'b1)
    wait_idle;
    $display("t_stale end");
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_normal;
    t_drop;
    t_idle;
    t_stale;
    test_done;
  end
endmodule
